// ===== tb/suc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module suc_peer (
  input wire logic pclk,
  input wire logic txd_out,
  input wire logic txd_oe,
  output logic rxd
);
  int width, gap, frames, nbits;
  time last;
  logic [11:0] got;
  initial rxd = 1'h1;
  // start bit length sets the sampling period
  always begin
    @(posedge pclk iff (txd_oe === 1'h1 && txd_out === 1'h0));
    gap = int'(($time - last) / 8);
    last = $time;
    width = 0;
    while (txd_out === 1'h0) begin
      @(posedge pclk);
      width++;
    end
    got = 12'h000;
    repeat (width / 2) @(posedge pclk);
    for (int i = 0; i < nbits; i++) begin
      if (i > 0) repeat (width) @(posedge pclk);
      got[i] = txd_out;
    end
    frames++;
  end
  task automatic send(input logic [11:0] bits, input int n, input int w);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (w) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/suc_usart_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module suc_usart_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_enable,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic rxd_owned,
  input wire logic rx_done_irq,
  input wire logic tx_done_irq,
  input wire logic tx_empty_irq
);
  default clocking dck @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] ctl;
  wire acc = psel && penable && pready;
  wire wr_b = acc && pwrite && paddr == 8'h04;
  // shadow of control b from bus writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl <= 8'h00;
    else if (wr_b) ctl <= pwdata[7:0];
  end
  chk_rx_irq_gate:
    assert property (rx_done_irq |-> ctl[7] && global_irq_enable || $past(ctl[7]) && $past(global_irq_enable))
      else $error("rx irq while gated");
  chk_tx_irq_gate:
    assert property (tx_done_irq |-> ctl[6] && global_irq_enable || $past(ctl[6]) && $past(global_irq_enable))
      else $error("tx irq while gated");
  chk_empty_irq_gate:
    assert property (tx_empty_irq |-> ctl[5] && global_irq_enable || $past(ctl[5]) && $past(global_irq_enable))
      else $error("empty irq while gated");
  chk_rx_pin_owner:
    assert property (wr_b |-> ##[1:2] rxd_owned == ctl[4])
      else $error("rx pin owner wrong");
  chk_tx_takeover:
    assert property (wr_b && pwdata[3] |-> ##[1:3] txd_oe)
      else $error("tx pin not taken");
  chk_release_idle:
    assert property ($fell(txd_oe) |-> !ctl[3] && $past(txd_out))
      else $error("tx pin released early");
  chk_zero_wait:
    assert property (psel && !penable |=> pready)
      else $error("no ready in access");
  chk_unmapped_err:
    assert property (acc |-> pslverr == (paddr > 8'h14))
      else $error("slave error wrong");
  chk_high_zero:
    assert property (acc && !pwrite && paddr == 8'h10 |-> prdata[31:4] == 28'h0)
      else $error("reserved baud bits set");
  cover property (rx_done_irq);
  cover property ($fell(txd_oe));
  cover property (acc && pslverr);
endmodule
bind suc_usart suc_usart_asserts suc_usart_asserts_inst (.*);
`default_nettype wire

// ===== tb/suc_usart_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "suc_regs.vh"
module suc_usart_tb;
  localparam logic [7:0] A_ST = `SUC_ADDR_STATUS_A;
  localparam logic [7:0] A_CB = `SUC_ADDR_CTRL_B;
  localparam logic [7:0] A_FC = `SUC_ADDR_FORMAT_C;
  localparam logic [7:0] A_BL = `SUC_ADDR_BAUD_LOW;
  localparam logic [7:0] A_BH = `SUC_ADDR_BAUD_HIGH;
  localparam logic [7:0] A_DT = `SUC_ADDR_DATA;
  logic pclk, presetn, psel, penable, pwrite, gie, err, sync_clock_pin, xck_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, q;
  wire [31:0] prdata;
  wire pready, pslverr, txd_out, txd_oe, rxd_owned, rxd, rx_irq, tx_irq, em_irq;
  int failures, num_checks, cyc;
  suc_usart suc_usart_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_irq_enable(gie), .rxd_pin(rxd), .sync_clock_pin_in(sync_clock_pin),
    .txd_out(txd_out), .txd_oe(txd_oe), .rxd_owned(rxd_owned), .sync_clock_pin_out(),
    .sync_clock_pin_oe(), .rx_done_irq(rx_irq), .tx_done_irq(tx_irq), .tx_empty_irq(em_irq));
  suc_peer suc_peer_inst (.pclk(pclk), .txd_out(txd_out), .txd_oe(txd_oe), .rxd(rxd));
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    // slave clock for sync mode, 32 pclk per period
    if (xck_en && cyc % 16 == 0) sync_clock_pin <= ~sync_clock_pin;
    if (cyc == 60000) begin
      failures++;
      conclude;
    end
  end
  task automatic conclude;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(q, e);
  endtask
  // read status until the given flag is up
  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      apb(1'h0, A_ST, 32'h0);
      k++;
    end while (q[b] !== 1'h1 && k < 400);
  endtask
  task automatic t_regs;
    rdc(A_ST, 32'h20);
    rdc(A_CB, 32'h00);
    rdc(A_FC, 32'h06);
    rdc(A_BL, 32'h00);
    apb(1'h0, 8'h18, 32'h0);
    check(err, 1'h1);
    check(q, 32'h0);
    wr(A_BH, 32'hFF);
    rdc(A_BH, 32'h0F);
    wr(A_BH, 32'h00);
    wr(A_BL, 32'h01);
    rdc(A_BL, 32'h01);
  endtask
  // four frame formats, two frames back to back each
  task automatic t_tx;
    logic [11:0] e;
    int par, stp, ds, nb, w;
    wr(A_CB, 32'h28);
    repeat (2) @(posedge pclk);
    check(txd_oe, 1'h1);
    check(em_irq, 1'h1);
    for (int i = 0; i < 4; i++) begin
      par = (i == 1) ? 2 : (i == 2) ? 3 : 0;
      stp = (i == 1) ? 1 : 0;
      ds = (i == 2) ? 1 : 0;
      nb = (i == 3) ? 9 : 8;
      w = (ds == 1) ? 16 : 32;
      wr(A_ST, (ds == 1) ? 32'h42 : 32'h40);
      wr(A_FC, 32'(par * 16 + stp * 8 + 6));
      wr(A_CB, (nb == 9) ? 32'h2C : 32'h28);
      suc_peer_inst.nbits = nb + 1 + stp + ((par != 0) ? 1 : 0);
      e = 12'hFFF;
      e[7:0] = 8'hA7;
      if (nb == 9) e[8] = 1'h0;
      if (par != 0) e[nb] = ^e[7:0] ^ (par == 3);
      e = e & ((12'h1 << suc_peer_inst.nbits) - 12'h1);
      wr(A_DT, 32'hA7);
      poll(5);
      wr(A_DT, 32'hA7);
      poll(6);
      check(suc_peer_inst.got, e);
      check(suc_peer_inst.gap, (1 + suc_peer_inst.nbits) * w);
      check(suc_peer_inst.width, w);
    end
  endtask
  task automatic t_drain;
    wr(A_ST, 32'h40);
    wr(A_FC, 32'h06);
    wr(A_CB, 32'h48);
    suc_peer_inst.nbits = 9;
    wr(A_DT, 32'hA7);
    wr(A_CB, 32'h40);
    check(txd_oe, 1'h1);
    poll(6);
    check(suc_peer_inst.got, 12'h1A7);
    check(txd_oe, 1'h0);
    check(tx_irq, 1'h1);
    gie <= 1'h0;
    repeat (2) @(posedge pclk);
    check(tx_irq, 1'h0);
    gie <= 1'h1;
    wr(A_ST, 32'h40);
  endtask
  // 9-bit even parity: good frame, then bad parity
  task automatic t_rx;
    wr(A_FC, 32'h26);
    wr(A_CB, 32'h94);
    repeat (2) @(posedge pclk);
    check(rxd_owned, 1'h1);
    suc_peer_inst.send({2'h3, 9'h1A5, 1'h0}, 12, 32);
    suc_peer_inst.send({2'h3, 9'h05A, 1'h0}, 12, 32);
    poll(7);
    check(rx_irq, 1'h1);
    rdc(A_ST, 32'hA0);
    rdc(A_CB, 32'h96);
    rdc(A_DT, 32'hA5);
    rdc(A_ST, 32'hA4);
    rdc(A_CB, 32'h94);
    rdc(A_DT, 32'h5A);
    rdc(A_ST, 32'h20);
    check(rx_irq, 1'h0);
    suc_peer_inst.send({2'h3, 9'h05A, 1'h0}, 12, 32);
    poll(7);
    wr(A_CB, 32'h84);
    rdc(A_ST, 32'h20);
    check(rxd_owned, 1'h0);
  endtask
  // sync slave mode, polarity 0: bits change on rising clock edges
  task automatic t_sync;
    wr(A_ST, 32'h40);
    wr(A_FC, 32'h46);
    wr(A_CB, 32'h08);
    suc_peer_inst.nbits = 9;
    xck_en <= 1'h1;
    wr(A_DT, 32'hA7);
    poll(6);
    check(suc_peer_inst.got, 12'h1A7);
    check(suc_peer_inst.width, 32);
    xck_en <= 1'h0;
  endtask
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    gie = 1'h0;
    sync_clock_pin = 1'h0;
    xck_en = 1'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    gie <= 1'h1;
    t_regs;
    t_tx;
    t_drain;
    t_rx;
    t_sync;
    conclude;
  end
endmodule
`default_nettype wire

// ===== verilog/suc_regs.vh
`ifndef SUC_REGS_VH
`define SUC_REGS_VH
// byte addresses on apb
`define SUC_ADDR_STATUS_A 8'h00
`define SUC_ADDR_CTRL_B 8'h04
`define SUC_ADDR_FORMAT_C 8'h08
`define SUC_ADDR_BAUD_LOW 8'h0C
`define SUC_ADDR_BAUD_HIGH 8'h10
`define SUC_ADDR_DATA 8'h14
// status a fields
`define SUC_A_RX_DONE 7
`define SUC_A_TX_DONE 6
`define SUC_A_TX_EMPTY 5
`define SUC_A_FRAME_ERR 4
`define SUC_A_OVERRUN 3
`define SUC_A_PARITY_ERR 2
`define SUC_A_DOUBLE 1
// control b fields
`define SUC_B_RX_IRQ_EN 7
`define SUC_B_TX_IRQ_EN 6
`define SUC_B_EMPTY_IRQ_EN 5
`define SUC_B_RX_ON 4
`define SUC_B_TX_ON 3
`define SUC_B_SIZE_MSB 2
`define SUC_B_RX_NINTH 1
`define SUC_B_TX_NINTH 0
// format c fields
`define SUC_C_SYNC 6
`define SUC_C_PAR_HI 5
`define SUC_C_PAR_LO 4
`define SUC_C_STOP2 3
`define SUC_C_SIZE_HI 2
`define SUC_C_SIZE_LO 1
`define SUC_C_POL 0
// reset values
`define SUC_RESET_A 8'h20
`define SUC_RESET_B 8'h00
`define SUC_RESET_C 8'h06
`define SUC_RESET_BAUD 12'h000
// oversampling per bit
`define SUC_OVERSAMPLE_NORMAL 5'h10
`define SUC_OVERSAMPLE_DOUBLE 5'h08
`endif

// ===== verilog/suc_usart.v
// Summary of operation
// - receive-done irq needs its enable, global enable and rx done flag
// - transmit-done irq needs its enable, global enable and tx done flag
// - buffer-empty irq needs its enable, global enable and empty flag
// - receiver owns rx pin while on; turning off flushes buffer and errors
// - transmitter owns tx pin while enabled, releases it when fully off
// - clearing transmit enable waits until shifter and buffer are empty
// - received ninth bit readable in control b; read before data
// - transmitted ninth bit from control b; write before data
// - mode bit 0 asynchronous, 1 synchronous
// - parity field: 00 off, 01 reserved, 10 even, 11 odd
// - parity generated on transmit, checked on receive, error flag on mismatch
// - transmitter sends one or two stop bits; receiver ignores setting
// - size code 000..011 gives 5..8 bits, 111 gives 9 bits
// - sync polarity selects change and sample edges of the clock
// - 12-bit baud divisor split over high and low byte registers
// - writing low byte reloads the prescaler at once
// - receive buffer is a two-entry fifo advanced by data reads
// - double speed changes per-bit divisor from 16 to 8
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`include "suc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module suc_usart (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire global_irq_enable,
  input wire rxd_pin,
  input wire sync_clock_pin_in,
  output reg txd_out,
  output reg txd_oe,
  output reg rxd_owned,
  output reg sync_clock_pin_out,
  output reg sync_clock_pin_oe,
  output reg rx_done_irq,
  output reg tx_done_irq,
  output reg tx_empty_irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_TAIL = 2'd3;

  reg [7:0] ctrl_b;
  reg [7:0] fmt_c;
  reg double_speed;
  reg [11:0] baud_divisor;
  reg [11:0] prescale;
  reg [4:0] os_cnt;
  reg tx_done_flag;
  reg tx_buf_full;
  reg [8:0] tx_buf;
  // receive fifo
  reg [8:0] rx_mem [0:1];
  reg [1:0] rx_err [0:1];
  reg rx_rd_ptr;
  reg [1:0] rx_count;
  reg overrun_flag;
  // synchronisers
  reg [1:0] rxd_sync;
  reg [1:0] xck_sync;
  reg xck_prev;
  // transmitter
  reg [1:0] tx_state;
  reg [10:0] tx_shift;
  reg [3:0] tx_left;
  reg [4:0] tx_os;
  reg tx_active;
  // receiver
  reg [1:0] rx_state;
  reg [9:0] rx_shift;
  reg [3:0] rx_left;
  reg [4:0] rx_os;
  reg rx_par_acc;

  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && penable && !pwrite;
  wire sync_mode = fmt_c[`SUC_C_SYNC];
  wire parity_on = fmt_c[`SUC_C_PAR_HI];
  wire parity_odd = fmt_c[`SUC_C_PAR_LO];
  wire [2:0] size_code = {ctrl_b[`SUC_B_SIZE_MSB], fmt_c[`SUC_C_SIZE_HI:`SUC_C_SIZE_LO]};
  wire tx_empty_flag = !tx_buf_full;
  wire rx_done_flag = rx_count != 2'd0;
  wire xck_in = xck_sync[1];
  wire rxd_in = rxd_sync[1];
  wire data_rd = apb_rd && paddr == `SUC_ADDR_DATA;
  wire [4:0] os_top = double_speed ? `SUC_OVERSAMPLE_DOUBLE : `SUC_OVERSAMPLE_NORMAL;

  // character size decode, reserved codes fall back to eight
  function [3:0] char_bits;
    input [2:0] code;
    begin
      case (code)
        3'h0: char_bits = 4'h5;
        3'h1: char_bits = 4'h6;
        3'h2: char_bits = 4'h7;
        3'h3: char_bits = 4'h8;
        3'h7: char_bits = 4'h9;
        default: char_bits = 4'h8;
      endcase
    end
  endfunction

  // parity over the active data bits
  function par_of;
    input [8:0] d;
    input [3:0] n;
    input odd;
    integer i;
    reg p;
    begin
      p = odd;
      for (i = 0; i < 9; i = i + 1) begin
        if (i < n)
          p = p ^ d[i];
      end
      par_of = p;
    end
  endfunction

  // baud tick: async from prescaler, sync from clock pin edges
  reg baud_tick;
  reg tx_edge;
  reg rx_edge;
  wire xck_rise = xck_in && !xck_prev;
  wire xck_fall = !xck_in && xck_prev;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 12'h000;
      baud_tick <= 1'b0;
      os_cnt <= 5'h00;
      xck_prev <= 1'b0;
      tx_edge <= 1'b0;
      rx_edge <= 1'b0;
      sync_clock_pin_out <= 1'b0;
    end else begin
      xck_prev <= xck_in;
      if (apb_wr && paddr == `SUC_ADDR_BAUD_LOW) begin
        prescale <= {baud_divisor[11:8], pwdata[7:0]};
        baud_tick <= 1'b0;
      end else if (prescale == 12'h000) begin
        prescale <= baud_divisor;
        baud_tick <= 1'b1;
      end else begin
        prescale <= prescale - 12'h001;
        baud_tick <= 1'b0;
      end
      if (baud_tick)
        sync_clock_pin_out <= ~sync_clock_pin_out;
      tx_edge <= sync_mode && (fmt_c[`SUC_C_POL] ? xck_fall : xck_rise);
      rx_edge <= sync_mode && (fmt_c[`SUC_C_POL] ? xck_rise : xck_fall);
      if (baud_tick)
        os_cnt <= (os_cnt + 5'h01 >= os_top) ? 5'h00 : os_cnt + 5'h01;
    end
  end
  wire async_bit = !sync_mode && baud_tick && (os_cnt + 5'h01 >= os_top);

  // synchronisers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_sync <= 2'b11;
      xck_sync <= 2'b00;
    end else begin
      rxd_sync <= {rxd_sync[0], rxd_pin};
      xck_sync <= {xck_sync[0], sync_clock_pin_in};
    end
  end

  // registers, transmitter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b <= `SUC_RESET_B;
      fmt_c <= `SUC_RESET_C;
      double_speed <= 1'b0;
      baud_divisor <= `SUC_RESET_BAUD;
      tx_buf_full <= 1'b0;
      tx_buf <= 9'h000;
      tx_done_flag <= 1'b0;
      tx_state <= ST_IDLE;
      tx_shift <= 11'h7FF;
      tx_left <= 4'h0;
      tx_os <= 5'h00;
      tx_active <= 1'b0;
    end else begin
      if (apb_wr) begin
        case (paddr)
          `SUC_ADDR_STATUS_A: begin
            double_speed <= pwdata[`SUC_A_DOUBLE];
          end
          `SUC_ADDR_CTRL_B: begin
            ctrl_b[7:2] <= pwdata[7:2];
            ctrl_b[`SUC_B_TX_NINTH] <= pwdata[`SUC_B_TX_NINTH];
          end
          `SUC_ADDR_FORMAT_C: fmt_c <= pwdata[7:0];
          `SUC_ADDR_BAUD_LOW: baud_divisor[7:0] <= pwdata[7:0];
          `SUC_ADDR_BAUD_HIGH: baud_divisor[11:8] <= pwdata[3:0];
          `SUC_ADDR_DATA: begin
            if (!tx_buf_full) begin
              tx_buf <= {ctrl_b[`SUC_B_TX_NINTH], pwdata[7:0]};
              tx_buf_full <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      ctrl_b[`SUC_B_RX_NINTH] <= rx_mem[rx_rd_ptr][8];
      // stay active while shifter or buffer busy
      tx_active <= ctrl_b[`SUC_B_TX_ON] || tx_buf_full || tx_state != ST_IDLE;
      if (tx_state == ST_IDLE) begin
        // start bit begins on a bit boundary so it lasts a full period
        if (tx_buf_full && tx_active && (async_bit || tx_edge)) begin
          tx_shift <= {2'b11, tx_buf};
          tx_buf_full <= 1'b0;
          tx_state <= ST_START;
          tx_os <= 5'h00;
        end
      end else if (async_bit || tx_edge) begin
        case (tx_state)
          ST_START: begin
            tx_state <= ST_DATA;
            tx_left <= char_bits(size_code);
            tx_os <= {4'h0, parity_on}; // parity slot marker
            tx_shift[10] <= par_of(tx_shift[8:0], char_bits(size_code), parity_odd);
          end
          ST_DATA: begin
            tx_shift[8:0] <= {1'b1, tx_shift[8:1]};
            if (tx_left == 4'h1) begin
              tx_state <= ST_TAIL;
              // parity slot plus one or two stops
              tx_left <= {3'h0, tx_os[0]} + 4'h1 + {3'h0, fmt_c[`SUC_C_STOP2]};
            end else
              tx_left <= tx_left - 4'h1;
          end
          ST_TAIL: begin
            tx_os[0] <= 1'b0;
            if (tx_left == 4'h1) begin
              // pending byte follows with no idle bit between frames
              if (tx_buf_full && tx_active) begin
                tx_shift <= {2'b11, tx_buf};
                tx_buf_full <= 1'b0;
                tx_state <= ST_START;
              end else begin
                tx_state <= ST_IDLE;
                tx_done_flag <= 1'b1;
              end
            end
            tx_left <= tx_left - 4'h1;
          end
          default: tx_state <= ST_IDLE;
        endcase
      end
      if (apb_wr && paddr == `SUC_ADDR_STATUS_A && pwdata[`SUC_A_TX_DONE]
          && !(tx_state == ST_TAIL && tx_left == 4'h1 && (async_bit || tx_edge) && !tx_buf_full))
        tx_done_flag <= 1'b0;
    end
  end

  // serial output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_out <= 1'b1;
      txd_oe <= 1'b0;
      rxd_owned <= 1'b0;
      sync_clock_pin_oe <= 1'b0;
    end else begin
      txd_oe <= tx_active;
      rxd_owned <= ctrl_b[`SUC_B_RX_ON];
      sync_clock_pin_oe <= 1'b0;
      case (tx_state)
        ST_START: txd_out <= 1'b0;
        ST_DATA: txd_out <= tx_shift[0];
        ST_TAIL: txd_out <= tx_os[0] ? tx_shift[10] : 1'b1;
        default: txd_out <= 1'b1;
      endcase
    end
  end

  // receiver and fifo
  wire rx_sample = sync_mode ? rx_edge : (baud_tick && rx_os == (os_top >> 1));
  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= ST_IDLE;
      rx_shift <= 10'h000;
      rx_left <= 4'h0;
      rx_os <= 5'h00;
      rx_par_acc <= 1'b0;
      rx_rd_ptr <= 1'b0;
      rx_count <= 2'd0;
      overrun_flag <= 1'b0;
      for (k = 0; k < 2; k = k + 1) begin
        rx_mem[k] <= 9'h000;
        rx_err[k] <= 2'b00;
      end
    end else if (!ctrl_b[`SUC_B_RX_ON]) begin
      rx_state <= ST_IDLE;
      rx_count <= 2'd0;
      overrun_flag <= 1'b0;
      rx_err[0] <= 2'b00;
      rx_err[1] <= 2'b00;
    end else begin
      if (!sync_mode && baud_tick)
        rx_os <= (rx_os + 5'h01 >= os_top) ? 5'h00 : rx_os + 5'h01;
      if (data_rd && rx_count != 2'd0) begin
        rx_rd_ptr <= ~rx_rd_ptr;
        overrun_flag <= 1'b0;
      end
      case (rx_state)
        ST_IDLE: begin
          if (!rxd_in) begin
            rx_state <= ST_START;
            rx_os <= 5'h00;
            if (rx_count == 2'd2 && !data_rd)
              overrun_flag <= 1'b1;
          end
        end
        ST_START: begin
          if (rx_sample) begin
            rx_state <= rxd_in ? ST_IDLE : ST_DATA;
            rx_left <= char_bits(size_code);
            rx_shift <= 10'h000;
            rx_par_acc <= parity_odd;
          end
        end
        ST_DATA: begin
          if (rx_sample) begin
            rx_shift <= {rx_shift[8:0], rxd_in};
            rx_par_acc <= rx_par_acc ^ rxd_in;
            if (rx_left == 4'h1) begin
              rx_state <= ST_TAIL;
              rx_left <= parity_on ? 4'h2 : 4'h1; // one stop checked
            end else
              rx_left <= rx_left - 4'h1;
          end
        end
        ST_TAIL: begin
          if (rx_sample) begin
            if (rx_left == 4'h2)
              rx_par_acc <= rx_par_acc ^ rxd_in;
            else begin
              rx_state <= ST_IDLE;
              if (rx_count != 2'd2 || data_rd) begin
                rx_mem[rx_rd_ptr ^ rx_count[0]] <= rev9(rx_shift[8:0], char_bits(size_code));
                rx_err[rx_rd_ptr ^ rx_count[0]] <= {!rxd_in, parity_on && rx_par_acc};
              end
            end
            rx_left <= rx_left - 4'h1;
          end
        end
        default: rx_state <= ST_IDLE;
      endcase
      rx_count <= rx_count + {1'b0, rx_state == ST_TAIL && rx_sample && rx_left == 4'h1
                  && (rx_count != 2'd2 || data_rd)} - {1'b0, data_rd && rx_count != 2'd0};
    end
  end

  // bits arrive lsb first into the bottom of the shifter
  function [8:0] rev9;
    input [8:0] s;
    input [3:0] n;
    integer j;
    begin
      rev9 = 9'h000;
      for (j = 0; j < 9; j = j + 1) begin
        if (j < n)
          rev9[j] = s[n - 1 - j];
      end
    end
  endfunction

  // apb answer, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rx_done_irq <= 1'b0;
      tx_done_irq <= 1'b0;
      tx_empty_irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > `SUC_ADDR_DATA;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SUC_ADDR_STATUS_A: prdata <= {24'h000000, rx_done_flag, tx_done_flag, tx_empty_flag,
                                         rx_err[rx_rd_ptr][1] && rx_done_flag, overrun_flag,
                                         rx_err[rx_rd_ptr][0] && rx_done_flag, double_speed, 1'b0};
          `SUC_ADDR_CTRL_B: prdata <= {24'h000000, ctrl_b};
          `SUC_ADDR_FORMAT_C: prdata <= {24'h000000, fmt_c};
          `SUC_ADDR_BAUD_LOW: prdata <= {24'h000000, baud_divisor[7:0]};
          `SUC_ADDR_BAUD_HIGH: prdata <= {28'h0000000, baud_divisor[11:8]};
          `SUC_ADDR_DATA: prdata <= {24'h000000, rx_mem[rx_rd_ptr][7:0]};
          default: prdata <= 32'h00000000;
        endcase
      end
      rx_done_irq <= ctrl_b[`SUC_B_RX_IRQ_EN] && global_irq_enable && rx_done_flag;
      tx_done_irq <= ctrl_b[`SUC_B_TX_IRQ_EN] && global_irq_enable && tx_done_flag;
      tx_empty_irq <= ctrl_b[`SUC_B_EMPTY_IRQ_EN] && global_irq_enable && tx_empty_flag;
    end
  end
endmodule
`default_nettype wire
